/* core/crc8_unit.sv */
`timescale 1ns/1ps

module crc8_unit #(
  parameter logic [7:0] POLY = 8'h07
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic enable,
  input wire logic bit_valid,
  input wire logic bit_in,
  output logic [7:0] crc
);

  logic feedback;

  assign feedback = crc[7] ^ bit_in;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc <= 8'h00;
    end else if (clear || !enable) begin
      crc <= 8'h00;
    end else if (bit_valid) begin
      crc <= {crc[6:0], 1'b0} ^ (feedback ? POLY : 8'h00);
    end
  end

endmodule

/* core/i2c_control_one.sv */
// How it works
// - Soft reset bit holds engine in reset
// - Crc transfer bit cleared by hardware events
// - Lost arbitration makes crc result invalid
// - Position clear: ack/crc apply to current byte
// - Position set: ack/crc apply to next byte
// - Ack enable acknowledges received bytes, except a byte ended by slave stop request
// - Stop request makes stop, cleared on stop
// - Slave stop request releases lines after byte
// - Start request makes start, then self clears
// - Slave stretches clock unless stretch disabled
// - General call accept acks address zero
// - Crc check enable switches crc unit
// - Disable finishes transfer, then clears bits
// - Registers take half-word or word access
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "i2c_ctl_map.svh"

module i2c_control_one #(
  parameter logic [6:0] OWN_ADDR = `OWN_ADDR_DEF,
  parameter int HALF_CYC = `HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire i2c_ctl_pkg::apb_addr_t paddr,
  input wire i2c_ctl_pkg::apb_data_t pwdata,
  input wire logic [3:0] pstrb,
  output i2c_ctl_pkg::apb_data_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);
  import i2c_ctl_pkg::*;

  // ****************************************
  // Line sampling
  // ****************************************
  logic scl_s, sda_s, scl_q_ff, sda_q_ff;
  logic start_det, stop_det, scl_rise, scl_fall;

  line_sync #(.RESET_VAL(`IDLE_LINE)) u_scl_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(scl_i),
    .sync_out(scl_s)
  );

  line_sync #(.RESET_VAL(`IDLE_LINE)) u_sda_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(sda_i),
    .sync_out(sda_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q_ff <= `IDLE_LINE;
      sda_q_ff <= `IDLE_LINE;
    end else begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
    end
  end

  assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign stop_det = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  assign scl_rise = scl_s & ~scl_q_ff;
  assign scl_fall = ~scl_s & scl_q_ff;

  // ****************************************
  // Declarations
  // ****************************************
  ctrl_word_t ctrl_ff, nxt_ctrl, wr_val;
  slave_state_t slv_ff;
  master_state_t mst_ff;
  logic pready_ff, pslverr_ff;
  apb_data_t prdata_ff;
  logic wr_hit, wr_ctrl, wr_stat, acc_first;
  logic srst, en, acke, ackp, crcx, stopr, startr, strd, gca, crce;
  logic busy_ff, master_ff, addr_flag_ff, byte_flag_ff, arb_ff, crc_err_ff;
  logic crc_valid_ff, ack_next_ff, crc_next_ff, ack_drv_ff, scl_hold_ff;
  logic [3:0] cnt_ff;
  logic [7:0] shift_ff, crc_val;
  logic [11:0] timer_ff;
  logic ack_use, crc_mark, addr_hit, addr_done, byte_done, crc_done;
  logic start_sent, arb_evt, disabled_idle;
  logic scl_o_ff, sda_o_ff, scl_oe_n_ff, sda_oe_n_ff;

  assign srst = ctrl_ff[`SRST_BIT];
  assign en = ctrl_ff[`EN_BIT];
  assign acke = ctrl_ff[`ACKE_BIT];
  assign ackp = ctrl_ff[`ACKP_BIT];
  assign crcx = ctrl_ff[`CRCX_BIT];
  assign stopr = ctrl_ff[`STOPR_BIT];
  assign startr = ctrl_ff[`STARTR_BIT];
  assign strd = ctrl_ff[`STRD_BIT];
  assign gca = ctrl_ff[`GCA_BIT];
  assign crce = ctrl_ff[`CRCE_BIT];

  // ****************************************
  // APB slave
  // ****************************************
  assign acc_first = psel & penable & ~pready_ff;
  assign wr_hit = psel & penable & pready_ff & pwrite;
  assign wr_ctrl = wr_hit & (paddr == `CTRL_OFS);
  assign wr_stat = wr_hit & (paddr == `STAT_OFS);
  assign wr_val = {pstrb[1] ? pwdata[15:8] : ctrl_ff[15:8],
                   pstrb[0] ? pwdata[7:0] : ctrl_ff[7:0]} & `CTRL_WMASK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= acc_first;
      pslverr_ff <= acc_first & (paddr != `CTRL_OFS) & (paddr != `STAT_OFS);
      if (acc_first && !pwrite) begin
        if (paddr == `CTRL_OFS) begin
          prdata_ff <= {16'h0000, ctrl_ff};
        end else if (paddr == `STAT_OFS) begin
          prdata_ff <= {16'h0000, crc_val, 1'b0, crc_valid_ff, crc_err_ff, arb_ff,
                        master_ff, byte_flag_ff, addr_flag_ff, busy_ff};
        end else begin
          prdata_ff <= 32'h0000_0000;
        end
      end
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  assign disabled_idle = ~en & ~busy_ff;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (crc_done || start_det || stop_det) begin
      nxt_ctrl[`CRCX_BIT] = 1'b0;
    end
    if (stop_det) begin
      nxt_ctrl[`STOPR_BIT] = 1'b0;
    end
    if (start_sent) begin
      nxt_ctrl[`STARTR_BIT] = 1'b0;
    end
    if (disabled_idle) begin
      nxt_ctrl = nxt_ctrl & ~(16'h1F00);
    end
    if (wr_ctrl) begin
      nxt_ctrl = wr_val;
    end
    if (nxt_ctrl[`SRST_BIT]) begin
      nxt_ctrl = nxt_ctrl & 16'h8000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ****************************************
  // Bus state and status flags
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
      crc_valid_ff <= 1'b0;
    end else if (srst) begin
      busy_ff <= 1'b0;
      crc_valid_ff <= 1'b0;
    end else begin
      if (start_det) begin
        busy_ff <= 1'b1;
      end else if (stop_det) begin
        busy_ff <= 1'b0;
      end
      if (arb_evt) begin
        crc_valid_ff <= 1'b0;
      end else if (start_det) begin
        crc_valid_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_flag_ff <= 1'b0;
      byte_flag_ff <= 1'b0;
      arb_ff <= 1'b0;
      crc_err_ff <= 1'b0;
    end else if (srst) begin
      addr_flag_ff <= 1'b0;
      byte_flag_ff <= 1'b0;
      arb_ff <= 1'b0;
      crc_err_ff <= 1'b0;
    end else begin
      if (wr_stat && pstrb[0]) begin
        addr_flag_ff <= addr_flag_ff & ~pwdata[`ST_AMATCH_BIT];
        byte_flag_ff <= byte_flag_ff & ~pwdata[`ST_BYTEF_BIT];
        arb_ff <= arb_ff & ~pwdata[`ST_ARBL_BIT];
        crc_err_ff <= crc_err_ff & ~pwdata[`ST_CRCERR_BIT];
      end
      if (addr_done && addr_hit) begin
        addr_flag_ff <= 1'b1;
      end
      if (byte_done) begin
        byte_flag_ff <= 1'b1;
      end
      if (arb_evt) begin
        arb_ff <= 1'b1;
      end
      if (crc_done && crce && crc_valid_ff && (crc_val != 8'h00)) begin
        crc_err_ff <= 1'b1;
      end
    end
  end

  // ****************************************
  // Packet error check
  // ****************************************
  crc8_unit #(.POLY(`CRC_POLY)) u_crc (
    .clk(pclk),
    .rst_n(presetn),
    .clear(start_det | srst),
    .enable(crce),
    .bit_valid(scl_rise & ((slv_ff == S_ADDR) | (slv_ff == S_DATA)) & (cnt_ff != 4'h8)),
    .bit_in(sda_s),
    .crc(crc_val)
  );

  // ****************************************
  // Slave receiver
  // ****************************************
  assign ack_use = ackp ? ack_next_ff : acke;
  assign crc_mark = ackp ? crc_next_ff : crcx;
  assign addr_hit = (shift_ff[7:1] == OWN_ADDR) | ((shift_ff[7:1] == 7'h00) & gca);
  assign addr_done = (slv_ff == S_ADDR) & (cnt_ff == 4'h8) & scl_fall;
  assign byte_done = (slv_ff == S_DATA) & (cnt_ff == 4'h8) & scl_fall;
  assign crc_done = byte_done & crc_mark;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slv_ff <= S_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ack_drv_ff <= 1'b0;
      ack_next_ff <= 1'b0;
      crc_next_ff <= 1'b0;
    end else if (srst) begin
      slv_ff <= S_IDLE;
      ack_drv_ff <= 1'b0;
    end else if (stop_det) begin
      slv_ff <= S_IDLE;
      ack_drv_ff <= 1'b0;
    end else if (start_det) begin
      slv_ff <= en ? S_ADDR : S_IDLE;
      cnt_ff <= 4'h0;
      ack_drv_ff <= 1'b0;
    end else begin
      if (addr_done || byte_done) begin
        ack_next_ff <= acke;
        crc_next_ff <= crcx;
      end
      case (slv_ff)
        S_ADDR, S_DATA: begin
          if (scl_rise && cnt_ff != 4'h8) begin
            shift_ff <= {shift_ff[6:0], sda_s};
            cnt_ff <= cnt_ff + 4'h1;
          end
          if (addr_done) begin
            slv_ff <= addr_hit ? S_AACK : S_IDLE;
            ack_drv_ff <= addr_hit & ack_use;
          end else if (byte_done) begin
            if (stopr && mst_ff == M_IDLE) begin
              slv_ff <= S_IDLE;
            end else begin
              slv_ff <= S_DACK;
              ack_drv_ff <= ack_use;
            end
          end
        end
        S_AACK, S_DACK: begin
          if (scl_fall) begin
            slv_ff <= S_DATA;
            cnt_ff <= 4'h0;
            ack_drv_ff <= 1'b0;
          end
        end
        default: begin
          slv_ff <= S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_hold_ff <= 1'b0;
    end else begin
      scl_hold_ff <= ~srst & ~strd & (slv_ff != S_IDLE) & (addr_flag_ff | byte_flag_ff)
                     & (scl_hold_ff | scl_fall);
    end
  end

  // ****************************************
  // Master start and stop generator
  // ****************************************
  assign start_sent = (mst_ff == M_START) & (timer_ff == 12'h000) & scl_s;
  assign arb_evt = ((mst_ff == M_START) & ~scl_s)
                 | ((mst_ff == M_STOP_B) & (timer_ff == 12'h000) & ~sda_s);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_ff <= M_IDLE;
      timer_ff <= 12'h000;
      master_ff <= 1'b0;
    end else if (srst) begin
      mst_ff <= M_IDLE;
      timer_ff <= 12'h000;
      master_ff <= 1'b0;
    end else begin
      if (timer_ff != 12'h000) begin
        timer_ff <= timer_ff - 12'h001;
      end
      case (mst_ff)
        M_IDLE: begin
          master_ff <= 1'b0;
          if (startr && en && !busy_ff && slv_ff == S_IDLE) begin
            mst_ff <= M_START;
            timer_ff <= 12'(HALF_CYC - 1);
          end
        end
        M_START: begin
          if (arb_evt) begin
            mst_ff <= M_IDLE;
          end else if (start_sent) begin
            mst_ff <= M_HOLD;
            master_ff <= 1'b1;
          end
        end
        M_HOLD: begin
          if (stopr) begin
            mst_ff <= M_STOP_A;
            timer_ff <= 12'(HALF_CYC - 1);
          end
        end
        M_STOP_A: begin
          if (timer_ff == 12'h000) begin
            mst_ff <= M_STOP_B;
            timer_ff <= 12'(HALF_CYC - 1);
          end
        end
        M_STOP_B: begin
          if (timer_ff == 12'h000) begin
            mst_ff <= M_IDLE;
          end
        end
        default: begin
          mst_ff <= M_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Line drivers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_o_ff <= 1'b0;
      sda_o_ff <= 1'b0;
      scl_oe_n_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
    end else begin
      scl_o_ff <= 1'b0;
      sda_o_ff <= 1'b0;
      scl_oe_n_ff <= ~((mst_ff == M_HOLD) | scl_hold_ff);
      sda_oe_n_ff <= ~((mst_ff == M_START) | (mst_ff == M_HOLD) | (mst_ff == M_STOP_A)
                     | (((slv_ff == S_AACK) | (slv_ff == S_DACK)) & ack_drv_ff));
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign scl_o = scl_o_ff;
  assign sda_o = sda_o_ff;
  assign scl_oe_n = scl_oe_n_ff;
  assign sda_oe_n = sda_oe_n_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_soft_reset_hold: assert property (
    srst |=> (slv_ff == S_IDLE) && (mst_ff == M_IDLE)
  ) else $error("soft reset did not idle the engine");

  chk_crc_bit_clear: assert property (
    (start_det || stop_det) && !wr_ctrl |=> !crcx
  ) else $error("crc transfer bit survived start or stop");

  chk_crc_invalid: assert property (
    arb_evt |=> !crc_valid_ff [*2]
  ) else $error("crc still valid after lost arbitration");

  chk_ack_disable_clear: assert property (
    disabled_idle && !wr_ctrl |=> !acke && !ackp && !startr
  ) else $error("control bits kept while disabled");

  chk_stop_clear: assert property (
    stop_det && !wr_ctrl |=> !stopr
  ) else $error("stop request not cleared on stop");

  chk_slave_release: assert property (
    byte_done && stopr && (mst_ff == M_IDLE) && !srst && !stop_det && !start_det
    |=> (slv_ff == S_IDLE) ##1 sda_oe_n
  ) else $error("slave did not release lines after byte");

  chk_start_clear: assert property (
    start_sent && !wr_ctrl |=> !startr && master_ff
  ) else $error("start request not cleared after start");

  chk_stretch_gate: assert property (
    $rose(scl_hold_ff) |-> $past(!strd) ##1 !scl_oe_n
  ) else $error("clock held low with stretching disabled");

  chk_gc_nack: assert property (
    addr_done && !srst && !start_det && !stop_det && shift_ff[7:1] == 7'h00 && !gca
    && OWN_ADDR != 7'h00 |=> slv_ff == S_IDLE
  ) else $error("general call accepted while disabled");

  chk_apb_ready: assert property (
    acc_first |=> pready ##1 !pready
  ) else $error("register access not answered in one wait state");

endmodule

/* core/i2c_ctl_map.svh */
`ifndef I2C_CTL_MAP_SVH
`define I2C_CTL_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04

// ****************************************
// Control word layout
// ****************************************
`define CTRL_RESET 16'h0000
`define CTRL_WMASK 16'h9FE1
`define SRST_BIT 15
`define CRCX_BIT 12
`define ACKP_BIT 11
`define ACKE_BIT 10
`define STOPR_BIT 9
`define STARTR_BIT 8
`define STRD_BIT 7
`define GCA_BIT 6
`define CRCE_BIT 5
`define EN_BIT 0

// ****************************************
// Status word layout
// ****************************************
`define ST_BUSY_BIT 0
`define ST_AMATCH_BIT 1
`define ST_BYTEF_BIT 2
`define ST_ARBL_BIT 4
`define ST_CRCERR_BIT 5

// ****************************************
// Timing and constants
// ****************************************
`define HALF_NS 5000
`define CLK_MHZ 20
`define HALF_CYC ((`HALF_NS * `CLK_MHZ + 999) / 1000)
`define CRC_POLY 8'h07
`define OWN_ADDR_DEF 7'h3A
`define IDLE_LINE 1'b1

`endif

/* core/i2c_ctl_pkg.sv */
package i2c_ctl_pkg;

  typedef logic [31:0] apb_data_t;
  typedef logic [7:0] apb_addr_t;
  typedef logic [15:0] ctrl_word_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_AACK = 3'b010,
    S_DATA = 3'b011,
    S_DACK = 3'b100
  } slave_state_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_HOLD = 3'b010,
    M_STOP_A = 3'b011,
    M_STOP_B = 3'b100
  } master_state_t;

endpackage

/* core/line_sync.sv */
`timescale 1ns/1ps

module line_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule

/* dv/i2c_control_register_one_test.sv */
`timescale 1ns/1ps

module i2c_control_register_one_test;
  import i2c_ctl_pkg::*;
  typedef struct {
    apb_addr_t addr;
    apb_data_t wdata;
    logic [3:0] strb;
    apb_data_t exp;
    logic err;
  } row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  apb_addr_t paddr = 8'h00;
  apb_data_t pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  apb_data_t prdata;
  logic pready, pslverr, scl_oe_n, sda_oe_n, scl_pull, sda_pull, nack, rerr;
  wire scl_line = scl_oe_n & ~scl_pull;
  wire sda_line = sda_oe_n & ~sda_pull;
  int mismatches = 0;
  int total_checks = 0;
  apb_data_t rdat;
  row_t rows[5];
  logic [7:0] gadr[4] = '{8'h00, 8'h00, 8'h22, 8'h74};
  apb_data_t gctl[4] = '{32'h0481, 32'h04C1, 32'h04C1, 32'h00C1};
  logic gnk[4] = '{1'b1, 1'b0, 1'b1, 1'b1};

  always #25 pclk = ~pclk;

  i2c_control_one #(.OWN_ADDR(7'h3A), .HALF_CYC(4)) u_i2c_control_one (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl_line), .scl_o(), .scl_oe_n(scl_oe_n),
    .sda_i(sda_line), .sda_o(), .sda_oe_n(sda_oe_n)
  );

  i2c_remote_master u_i2c_remote_master (
    .pclk(pclk), .scl(scl_line), .sda(sda_line), .scl_pull(scl_pull), .sda_pull(sda_pull)
  );

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic apb(input apb_addr_t a, input logic w, input apb_data_t d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk(input apb_data_t got, input apb_data_t exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input apb_addr_t a, input apb_data_t d);
    apb(a, 1'b1, d, 4'hF);
  endtask

  task automatic rd(input apb_addr_t a, input apb_data_t exp);
    apb(a, 1'b0, 32'h0, 4'hF);
    chk(rdat, exp);
  endtask

  task automatic poll(input apb_addr_t a, input apb_data_t m, input apb_data_t exp);
    int n;
    n = 0;
    do begin
      apb(a, 1'b0, 32'h0, 4'hF);
      n++;
    end while ((rdat & m) !== exp && n < 60);
    chk(rdat & m, exp);
  endtask

  task automatic pins(input logic [1:0] exp);
    repeat (3) @(posedge pclk);
    chk({30'h0, scl_oe_n, sda_oe_n}, {30'h0, exp});
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rows[0] = '{8'h00, 32'h0000_60E1, 4'h3, 32'h0000_00E1, 1'b0};
    rows[1] = '{8'h00, 32'hFFFF_0C21, 4'h3, 32'h0000_0C21, 1'b0};
    rows[2] = '{8'h00, 32'h0000_00FF, 4'h1, 32'h0000_0CE1, 1'b0};
    rows[3] = '{8'h00, 32'h0000_081E, 4'h3, 32'h0000_0000, 1'b0};
    rows[4] = '{8'h08, 32'h0000_FFFF, 4'h3, 32'h0000_0000, 1'b1};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    rd(8'h00, 32'h0);
    pins(2'b11);
    foreach (rows[i]) begin
      apb(rows[i].addr, 1'b1, rows[i].wdata, rows[i].strb);
      chk({31'h0, rerr}, {31'h0, rows[i].err});
      apb(rows[i].addr, 1'b0, 32'h0, 4'hF);
      chk(rdat, rows[i].exp);
    end
    // Slave reception with stretching
    wr(8'h00, 32'h0421);
    u_i2c_remote_master.start();
    u_i2c_remote_master.send(8'h74, nack);
    chk({31'h0, nack}, 32'h0);
    poll(8'h04, 32'h2, 32'h2);
    pins(2'b01);
    wr(8'h04, 32'h2);
    pins(2'b11);
    u_i2c_remote_master.send(8'hA5, nack);
    chk({31'h0, nack}, 32'h0);
    poll(8'h04, 32'h4, 32'h4);
    wr(8'h00, 32'h00A1);
    wr(8'h04, 32'h4);
    u_i2c_remote_master.send(8'h5A, nack);
    chk({31'h0, nack}, 32'h1);
    pins(2'b11);
    u_i2c_remote_master.stop();
    wr(8'h04, 32'h36);
    // Address acceptance cases
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, gctl[i]);
      u_i2c_remote_master.start();
      u_i2c_remote_master.send(gadr[i], nack);
      chk({31'h0, nack}, {31'h0, gnk[i]});
      wr(8'h04, 32'h36);
      u_i2c_remote_master.stop();
    end
    // Hardware clears on start and stop
    wr(8'h00, 32'h1201);
    u_i2c_remote_master.start();
    poll(8'h00, 32'h1000, 32'h0);
    rd(8'h00, 32'h0201);
    u_i2c_remote_master.stop();
    poll(8'h00, 32'h0200, 32'h0);
    wr(8'h04, 32'h36);
    // Master start and stop
    wr(8'h00, 32'h0101);
    poll(8'h00, 32'h0100, 32'h0);
    chk({31'h0, scl_oe_n}, 32'h0);
    wr(8'h00, 32'h0201);
    poll(8'h00, 32'h0200, 32'h0);
    pins(2'b11);
    // Soft reset
    wr(8'h00, 32'h80E1);
    rd(8'h00, 32'h8000);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h0);
    print_verdict();
  end

  initial begin
    repeat (40000) @(posedge pclk);
    mismatches++;
    print_verdict();
  end
endmodule

/* dv/i2c_remote_master.sv */
`timescale 1ns/1ps

// ****************************************
// Remote master on the two-wire link
// ****************************************
module i2c_remote_master (
  input wire logic pclk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull
);
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  // Half of the link period
  task automatic half();
    repeat (4) @(posedge pclk);
  endtask

  // Release the clock, wait out any stretch
  task automatic rise();
    int n;
    n = 0;
    scl_pull <= 1'b0;
    do begin
      @(posedge pclk);
      n++;
    end while (scl !== 1'b1 && n < 3000);
    half();
  endtask

  task automatic start();
    sda_pull <= 1'b1;
    half();
    scl_pull <= 1'b1;
    half();
  endtask

  // Eight bits MSB first, ninth clock returns the answer
  task automatic send(input logic [7:0] d, output logic nack);
    logic [8:0] v;
    v = {d, 1'b1};
    nack = 1'b1;
    for (int i = 8; i >= 0; i--) begin
      @(posedge pclk);
      sda_pull <= ~v[i];
      half();
      rise();
      if (i == 0) begin
        nack = sda;
      end
      scl_pull <= 1'b1;
    end
  endtask

  task automatic stop();
    @(posedge pclk);
    sda_pull <= 1'b1;
    half();
    rise();
    sda_pull <= 1'b0;
    half();
  endtask
endmodule
